// >>> pkg/ptlre_defs.svh
// Constants for the port, table, logic, return and rotate execution block
`ifndef PTLRE_DEFS_SVH
`define PTLRE_DEFS_SVH
`define PTLRE_OP_NOP        8'h00
`define PTLRE_OP_BUS_OUT    8'h02
`define PTLRE_OP_OR_IMM     8'h43
`define PTLRE_OP_PAGE_RD    8'hA3
`define PTLRE_OP_FIXED_RD   8'hE3
`define PTLRE_OP_RET        8'h83
`define PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS       8'h93
`define PTLRE_OP_BUS_OR     8'h88
`define PTLRE_OP_RL         8'hE7
`define PTLRE_OP_RLC        8'hF7
`define PTLRE_OP_RR         8'h77
`define PTLRE_HI_EXP_WR     6'h0F
`define PTLRE_HI_EXP_OR     6'h23
`define PTLRE_HI_PORT_OUT   6'h0E
`define PTLRE_HI_PORT_OR    6'h22
`define PTLRE_HI_XRD        7'h40
`define PTLRE_HI_XWR        7'h48
`define PTLRE_HI_OR_IND     7'h20
`define PTLRE_HI_OR_REG     5'h09
`define PTLRE_HI_BUS_IN     8'h08
`define PTLRE_FIXED_PAGE    3'h3
`define PTLRE_BUS_TRASH     8'hFF
`define PTLRE_ACC_RST       8'h00
`define PTLRE_PSW_RST       8'h08
`define PTLRE_PC_RST        12'h000
`define PTLRE_BUS_RST       8'h00
`define PTLRE_PORT_RST      8'hFF
`endif

// >>> pkg/ptlre_pkg.sv
// Types for the port, table, logic, return and rotate execution block
package ptlre_pkg;
   typedef enum logic [1:0] {PTLRE_FETCH, PTLRE_SECOND, PTLRE_STACK} ptlre_state_e;
   typedef struct packed {
      logic       valid;
      logic [1:0] port;
      logic       is_or;
      logic [3:0] data;
   } ptlre_exp_s;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ptlre_xmem_s;
endpackage : ptlre_pkg

// >>> rtl/ptlre_core.sv
// Execution core for port, table, logic, return and rotate instructions
`timescale 1ns/100ps
`include "ptlre_defs.svh"
module ptlre_core
   import ptlre_pkg::*;
#(
   parameter int PC_W = 12
)(
   input  wire logic            CLK_SYS,
   input  wire logic            RST_N,
   input  wire logic [7:0]      PROG_DATA,
   output logic [PC_W-1:0]      PROG_ADDR,
   output logic                 PROG_FETCH_IS_DATA,
   input  wire logic [7:0]      REG_DATA,
   output logic [2:0]           REG_SEL,
   input  wire logic [7:0]      PTR_DATA,
   output logic                 PTR_SEL,
   input  wire logic [7:0]      IRAM_DATA,
   output logic [5:0]           IRAM_ADDR,
   input  wire logic [7:0]      XMEM_RDATA,
   output ptlre_xmem_s          XMEM,
   input  wire logic [3:0]      EXP_RDATA,
   output ptlre_exp_s           EXP,
   input  wire logic [7:0]      STACK_PC_LO,
   input  wire logic [7:0]      STACK_HI,
   output logic [2:0]           STACK_IDX,
   output logic [7:0]           BUS_LATCH,
   output logic [7:0]           PORT1_LATCH,
   output logic [7:0]           PORT2_LATCH,
   output logic [7:0]           ACC,
   output logic [7:0]           PROGRAM_STATUS_WORD,
   output logic                 INT_SERVICE_END
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ptlre_state_e     state;
   ptlre_state_e     next_state;
   logic [PC_W-1:0]  pc;
   logic [PC_W-1:0]  next_pc;
   logic [7:0]       op;
   logic [7:0]       next_acc;
   logic [7:0]       next_psw;
   logic [7:0]       next_bus;
   logic [7:0]       next_p1;
   logic [7:0]       next_p2;
   logic [PC_W-1:0]  next_addr;
   logic             next_is_data;
   ptlre_exp_s       next_exp;
   ptlre_xmem_s      next_xmem;
   logic             next_int_end;

   // ----------------------------------------------------------------
   // Decode on the fetched opcode; PROG_DATA holds the byte at PROG_ADDR
   // ----------------------------------------------------------------
   wire [7:0] cur     = (state == PTLRE_FETCH) ? PROG_DATA : op;
   wire is_exp_wr     = cur[7:2] == `PTLRE_HI_EXP_WR;
   wire is_exp_or     = cur[7:2] == `PTLRE_HI_EXP_OR;
   wire is_port_out   = cur[7:2] == `PTLRE_HI_PORT_OUT && cur[1:0] != 2'b00 && cur[1:0] != 2'b11;
   wire is_port_or    = cur[7:2] == `PTLRE_HI_PORT_OR && cur[1:0] != 2'b00 && cur[1:0] != 2'b11;
   wire is_bus_or     = cur == `PTLRE_OP_BUS_OR;
   wire is_xrd        = cur[7:1] == `PTLRE_HI_XRD;
   wire is_xwr        = cur[7:1] == `PTLRE_HI_XWR;
   wire is_or_ind     = cur[7:1] == `PTLRE_HI_OR_IND;
   wire is_or_reg     = cur[7:3] == `PTLRE_HI_OR_REG;
   wire is_two        = is_port_or || is_bus_or || is_exp_or || cur == `PTLRE_OP_OR_IMM ||
                        cur == `PTLRE_OP_PAGE_RD || cur == `PTLRE_OP_FIXED_RD ||
                        cur == `PTLRE_OP_RET || cur == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS || is_xrd || is_xwr;
   wire [PC_W-1:0] pc_inc = pc + {{(PC_W-1){1'b0}}, 1'b1};
   wire [2:0] sp_dec  = PROGRAM_STATUS_WORD[2:0] - 3'h1;
   assign REG_SEL     = cur[2:0];
   assign PTR_SEL     = cur[0];
   assign IRAM_ADDR   = PTR_DATA[5:0];
   // The pointer is already stepped down after the first cycle, so the second reads the entry it names
   assign STACK_IDX   = (state == PTLRE_SECOND) ? PROGRAM_STATUS_WORD[2:0] : sp_dec;

   always_comb begin
      next_state   = PTLRE_FETCH;
      next_pc      = pc;
      next_acc     = ACC;
      next_psw     = PROGRAM_STATUS_WORD;
      next_bus     = BUS_LATCH;
      next_p1      = PORT1_LATCH;
      next_p2      = PORT2_LATCH;
      next_addr    = PROG_ADDR;
      next_is_data = 1'b0;
      next_exp     = '0;
      next_xmem    = '0;
      next_int_end = 1'b0;
      case (state)
         PTLRE_FETCH: begin
            next_pc   = pc_inc;
            next_addr = pc_inc;
            if (is_two) begin
               next_state = PTLRE_SECOND;
            end
            if (is_exp_wr || is_exp_or) begin
               // The OR form only names the port here; its read data is not valid until the next cycle
               next_exp.valid = is_exp_wr;
               next_exp.port  = cur[1:0];
               next_exp.is_or = is_exp_or;
               next_exp.data  = ACC[3:0];
            end
            if (is_port_out) begin
               if (cur[0]) begin
                  next_p1 = ACC;
               end else begin
                  next_p2 = ACC;
               end
            end
            if (cur == `PTLRE_OP_BUS_OUT) begin
               next_bus = ACC;
            end
            if (is_or_reg) begin
               next_acc = ACC | REG_DATA;
            end
            if (is_or_ind) begin
               next_acc = ACC | IRAM_DATA;
            end
            if (cur == `PTLRE_OP_RL) begin
               next_acc = {ACC[6:0], ACC[7]};
            end
            if (cur == `PTLRE_OP_RLC) begin
               next_acc = {ACC[6:0], PROGRAM_STATUS_WORD[7]};
               next_psw = {ACC[7], PROGRAM_STATUS_WORD[6:0]};
            end
            if (cur == `PTLRE_OP_RR) begin
               next_acc = {ACC[0], ACC[7:1]};
            end
            if (cur == `PTLRE_OP_PAGE_RD) begin
               // pc_inc already points past the opcode, so an opcode at offset 255 reads its table from the next page
               next_addr    = {pc_inc[PC_W-1:8], ACC};
               next_is_data = 1'b1;
            end
            if (cur == `PTLRE_OP_FIXED_RD) begin
               next_addr    = {pc[PC_W-1:11], `PTLRE_FIXED_PAGE, ACC};
               next_is_data = 1'b1;
            end
            if (is_xrd || is_xwr) begin
               next_xmem.rd    = is_xrd;
               next_xmem.wr    = is_xwr;
               next_xmem.addr  = PTR_DATA;
               next_xmem.wdata = ACC;
               next_bus        = `PTLRE_BUS_TRASH;
            end
            if (cur == `PTLRE_OP_RET || cur == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS) begin
               next_psw = {PROGRAM_STATUS_WORD[7:3], sp_dec};
            end
         end
         PTLRE_SECOND: begin
            next_addr = pc;
            if (op == `PTLRE_OP_PAGE_RD || op == `PTLRE_OP_FIXED_RD) begin
               next_acc = PROG_DATA;
            end else if (is_xrd) begin
               next_acc = XMEM_RDATA;
            end else if (op == `PTLRE_OP_RET || op == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS) begin
               next_pc   = PC_W'({STACK_HI[3:0], STACK_PC_LO});
               next_addr = next_pc;
               if (op == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS) begin
                  next_psw     = {STACK_HI[7:4], PROGRAM_STATUS_WORD[3:0]};
                  next_int_end = 1'b1;
               end
            end else if (is_xwr) begin
               next_acc = ACC;
            end else if (is_exp_or) begin
               // Port read back through the registered selector, then combined and written
               next_exp.valid = 1'b1;
               next_exp.port  = op[1:0];
               next_exp.is_or = 1'b1;
               next_exp.data  = EXP_RDATA | ACC[3:0];
            end else begin
               // Immediate operand byte
               next_pc   = pc_inc;
               next_addr = pc_inc;
               if (op == `PTLRE_OP_OR_IMM) begin
                  next_acc = ACC | PROG_DATA;
               end else if (is_bus_or) begin
                  next_bus = BUS_LATCH | PROG_DATA;
               end else if (op[0]) begin
                  next_p1 = PORT1_LATCH | PROG_DATA;
               end else begin
                  next_p2 = PORT2_LATCH | PROG_DATA;
               end
            end
         end
         default: next_state = PTLRE_FETCH;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         state              <= PTLRE_FETCH;
         pc                 <= PC_W'(`PTLRE_PC_RST);
         op                 <= `PTLRE_OP_NOP;
         ACC                <= `PTLRE_ACC_RST;
         PROGRAM_STATUS_WORD                <= `PTLRE_PSW_RST;
         BUS_LATCH          <= `PTLRE_BUS_RST;
         PORT1_LATCH        <= `PTLRE_PORT_RST;
         PORT2_LATCH        <= `PTLRE_PORT_RST;
         PROG_ADDR          <= PC_W'(`PTLRE_PC_RST);
         PROG_FETCH_IS_DATA <= 1'b0;
         EXP                <= '0;
         XMEM               <= '0;
         INT_SERVICE_END    <= 1'b0;
      end else begin
         state              <= next_state;
         pc                 <= next_pc;
         op                 <= cur;
         ACC                <= next_acc;
         PROGRAM_STATUS_WORD                <= next_psw;
         BUS_LATCH          <= next_bus;
         PORT1_LATCH        <= next_p1;
         PORT2_LATCH        <= next_p2;
         PROG_ADDR          <= next_addr;
         PROG_FETCH_IS_DATA <= next_is_data;
         EXP                <= next_exp;
         XMEM               <= next_xmem;
         INT_SERVICE_END    <= next_int_end;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_exp_wr;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && is_exp_wr) |=> EXP.valid && EXP.data == $past(ACC[3:0]) && ACC == $past(ACC);
   endproperty
   a_exp_wr: assert property (p_exp_wr) else $error("expander write data wrong");
   property p_exp_port;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && (is_exp_wr || is_exp_or)) |=> EXP.port == $past(PROG_DATA[1:0]);
   endproperty
   a_exp_port: assert property (p_exp_port) else $error("expander port select wrong");
   property p_nop;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_NOP) |=>
         ACC == $past(ACC) && PROGRAM_STATUS_WORD == $past(PROGRAM_STATUS_WORD) && pc == $past(pc) + 1'b1;
   endproperty
   a_nop: assert property (p_nop) else $error("no-operation changed state");
   property p_page_rd;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_PAGE_RD) |=>
         PROG_ADDR[7:0] == $past(ACC) && PROG_FETCH_IS_DATA ##1 ACC == $past(PROG_DATA);
   endproperty
   a_page_rd: assert property (p_page_rd) else $error("page table read wrong");
   property p_fixed_rd;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_FIXED_RD) |=> PROG_ADDR[10:8] == 3'h3;
   endproperty
   a_fixed_rd: assert property (p_fixed_rd) else $error("fixed page not selected");
   property p_ret_sp;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_RET) |=>
         PROGRAM_STATUS_WORD[2:0] == $past(PROGRAM_STATUS_WORD[2:0]) - 3'h1 ##1 PROGRAM_STATUS_WORD[7:4] == $past(PROGRAM_STATUS_WORD[7:4], 2);
   endproperty
   a_ret_sp: assert property (p_ret_sp) else $error("return stack pointer wrong");
   property p_interrupt_exit_with_status_end;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS) |=> ##1 INT_SERVICE_END;
   endproperty
   a_interrupt_exit_with_status_end: assert property (p_interrupt_exit_with_status_end) else $error("service end missing");
   property p_rl;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_RL) |=>
         ACC == {$past(ACC[6:0]), $past(ACC[7])} && PROGRAM_STATUS_WORD[7] == $past(PROGRAM_STATUS_WORD[7]);
   endproperty
   a_rl: assert property (p_rl) else $error("left rotate wrong");
   property p_rlc;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_RLC) |=>
         PROGRAM_STATUS_WORD[7] == $past(ACC[7]) && ACC[0] == $past(PROGRAM_STATUS_WORD[7]);
   endproperty
   a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");
   property p_rr;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_RR) |=> ACC == {$past(ACC[0]), $past(ACC[7:1])};
   endproperty
   a_rr: assert property (p_rr) else $error("right rotate wrong");
   property p_bus_out;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_BUS_OUT) |=> BUS_LATCH == $past(ACC);
   endproperty
   a_bus_out: assert property (p_bus_out) else $error("bus latch not written");
   property p_exp_or;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_SECOND && is_exp_or) |=> EXP.valid && EXP.data == ($past(EXP_RDATA) | $past(ACC[3:0]));
   endproperty
   a_exp_or: assert property (p_exp_or) else $error("expander OR data wrong");
   property p_port_out;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && is_port_out) |=> ($past(PROG_DATA[0]) ? PORT1_LATCH : PORT2_LATCH) == $past(ACC);
   endproperty
   a_port_out: assert property (p_port_out) else $error("port latch not written");
   property p_xmem_bus;
      @(posedge CLK_SYS) disable iff (!rst_n)
      (state == PTLRE_FETCH && (is_xrd || is_xwr)) |=> BUS_LATCH == `PTLRE_BUS_TRASH && XMEM.addr == $past(PTR_DATA);
   endproperty
   a_xmem_bus: assert property (p_xmem_bus) else $error("external move left bus latch intact");
   c_ret:   cover property (@(posedge CLK_SYS) state == PTLRE_FETCH && PROG_DATA == `PTLRE_OP_INTERRUPT_EXIT_WITH_STATUS);
   c_xrd:   cover property (@(posedge CLK_SYS) XMEM.rd);
   c_exp:   cover property (@(posedge CLK_SYS) EXP.valid && EXP.is_or);
   c_table: cover property (@(posedge CLK_SYS) PROG_FETCH_IS_DATA);
   c_port_or: cover property (@(posedge CLK_SYS) state == PTLRE_SECOND && is_port_or);
endmodule : ptlre_core

// >>> test/ptlre_env_model.sv
// Behavioural memories, register file, expander ports and stack around the execution core
`timescale 1ns/100ps
module ptlre_env_model
   import ptlre_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [11:0] prog_addr,
   output logic [7:0]       prog_data,
   input  wire logic [2:0]  reg_sel,
   output logic [7:0]       reg_data,
   input  wire logic        ptr_sel,
   output logic [7:0]       ptr_data,
   input  wire logic [5:0]  iram_addr,
   output logic [7:0]       iram_data,
   input  ptlre_xmem_s      xmem,
   output logic [7:0]       xmem_rdata,
   input  ptlre_exp_s       exp_bus,
   output logic [3:0]       exp_rdata,
   input  wire logic [2:0]  stack_idx,
   output logic [7:0]       stack_pc_lo,
   output logic [7:0]       stack_hi
);
   logic [7:0] rom    [0:4095];
   logic [7:0] regs   [0:7];
   logic [7:0] ptr    [0:1];
   logic [7:0] iram   [0:63];
   logic [7:0] xram   [0:255];
   logic [3:0] xport  [0:3];
   logic [7:0] stk_lo [0:7];
   logic [7:0] stk_hi [0:7];
   // ----------------------------------------
   // Read paths
   // ----------------------------------------
   assign prog_data   = rom[prog_addr];
   assign reg_data    = regs[reg_sel];
   assign ptr_data    = ptr[ptr_sel];
   assign iram_data   = iram[iram_addr];
   // Released data bus shows the inverse, so a read outside the strobe cannot match by luck
   assign xmem_rdata  = xmem.rd ? xram[xmem.addr] : ~xram[xmem.addr];
   assign exp_rdata   = xport[exp_bus.port];
   assign stack_pc_lo = stk_lo[stack_idx];
   assign stack_hi    = stk_hi[stack_idx];
   // ----------------------------------------
   // Write paths
   // ----------------------------------------
   always @(posedge clk) begin
      if (xmem.wr) begin
         xram[xmem.addr] <= xmem.wdata;
      end
      if (exp_bus.valid) begin
         xport[exp_bus.port] <= exp_bus.data;
      end
   end
endmodule : ptlre_env_model

// >>> test/port_table_logic_return_exec_test.sv
// Self-checking bench: short programs run from reset, results compared afterwards
`timescale 1ns/100ps
module port_table_logic_return_exec_test;
   import ptlre_pkg::*;
   logic        CLK_SYS;
   logic        RST_N;
   logic [7:0]  prog_data, reg_data, ptr_data, iram_data, xmem_rdata, stack_pc_lo, stack_hi;
   logic [11:0] prog_addr;
   logic        is_data, ptr_sel, int_end;
   logic [2:0]  reg_sel, stack_idx;
   logic [5:0]  iram_addr;
   logic [3:0]  exp_rdata;
   ptlre_xmem_s xmem;
   ptlre_exp_s  exp_bus;
   logic [7:0]  bus_latch, port1_latch, port2_latch, acc, program_status_word;
   int          fail_count = 0;
   int          tests_run = 0;
   int          int_end_count = 0;
   // ----------------------------------------
   // Clock, instances, pulse counter
   // ----------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   ptlre_core #(.PC_W(12)) u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PROG_DATA(prog_data),
      .PROG_ADDR(prog_addr), .PROG_FETCH_IS_DATA(is_data), .REG_DATA(reg_data), .REG_SEL(reg_sel),
      .PTR_DATA(ptr_data), .PTR_SEL(ptr_sel), .IRAM_DATA(iram_data), .IRAM_ADDR(iram_addr),
      .XMEM_RDATA(xmem_rdata), .XMEM(xmem), .EXP_RDATA(exp_rdata), .EXP(exp_bus),
      .STACK_PC_LO(stack_pc_lo), .STACK_HI(stack_hi), .STACK_IDX(stack_idx), .BUS_LATCH(bus_latch),
      .PORT1_LATCH(port1_latch), .PORT2_LATCH(port2_latch), .ACC(acc), .PROGRAM_STATUS_WORD(program_status_word),
      .INT_SERVICE_END(int_end));
   ptlre_env_model u_env (.clk(CLK_SYS), .prog_addr(prog_addr), .prog_data(prog_data), .reg_sel(reg_sel),
      .reg_data(reg_data), .ptr_sel(ptr_sel), .ptr_data(ptr_data), .iram_addr(iram_addr),
      .iram_data(iram_data), .xmem(xmem), .xmem_rdata(xmem_rdata), .exp_bus(exp_bus),
      .exp_rdata(exp_rdata), .stack_idx(stack_idx), .stack_pc_lo(stack_pc_lo), .stack_hi(stack_hi));
   always @(posedge CLK_SYS) begin
      if (int_end === 1'b1) begin
         int_end_count <= int_end_count + 1;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp_v, input string what);
      tests_run++;
      if (seen !== exp_v) begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp_v);
      end
   endtask : check
   task automatic print_verdict;
      if (fail_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   // Holds the core in reset and blanks program memory so stray bytes act as no-ops
   task automatic start;
      @(posedge CLK_SYS);
      RST_N <= 1'b0;
      @(posedge CLK_SYS);
      for (int i = 0; i < 4096; i++) begin
         u_env.rom[i] = 8'h00;
      end
   endtask : start
   task automatic put(input logic [11:0] at, input logic [7:0] b [$]);
      foreach (b[i]) begin
         u_env.rom[at + 12'(i)] = b[i];
      end
   endtask : put
   // Releases reset and runs until the fetch address reaches the stop point
   task automatic go(input logic [11:0] stop);
      int n;
      repeat (5) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      n = 0;
      while (!(prog_addr === stop && is_data === 1'b0) && n < 2000) begin
         @(negedge CLK_SYS);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         $display("CHECK FAILED t=%0t fetch never reached %h", $time, stop);
         print_verdict();
      end
      repeat (2) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
   endtask : go
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      logic [3:0] xp_exp [0:3];
      RST_N <= 1'b0;
      xp_exp = '{4'h0, 4'h5, 4'h0, 4'h5};
      for (int i = 0; i < 4; i++) begin
         u_env.xport[i] = 4'h0;
      end
      start();
      put(12'h000, '{8'h43, 8'hA5, 8'h39, 8'h3A, 8'h3D, 8'h3F, 8'h02, 8'h88, 8'h10, 8'h89, 8'h0A,
                     8'h8A, 8'h42});
      go(12'h00D);
      check(acc, 8'hA5, "acc after nibble writes");
      check(port1_latch, 8'hAF, "port1");
      check(port2_latch, 8'hE7, "port2");
      check(bus_latch, 8'hB5, "bus or");
      for (int i = 0; i < 4; i++) begin
         check({4'h0, u_env.xport[i]}, {4'h0, xp_exp[i]}, "expander port");
      end
      // Distinct port values, so reading back the wrong port shows in the result
      u_env.xport[0] = 4'h8;
      u_env.xport[1] = 4'h4;
      u_env.xport[2] = 4'h2;
      u_env.xport[3] = 4'h1;
      u_env.xram[8'h37] = 8'h12;
      u_env.ptr[0] = 8'h37;
      u_env.ptr[1] = 8'hEC;
      u_env.iram[6'h2C] = 8'h40;
      u_env.regs[5] = 8'h81;
      start();
      put(12'h000, '{8'h02, 8'h80, 8'h4D, 8'h41, 8'h8D, 8'h91});
      go(12'h006);
      check(acc, 8'hD3, "acc after or chain");
      check(bus_latch, 8'hFF, "bus after external move");
      check(u_env.xram[8'hEC], 8'hD3, "external write");
      check({4'h0, u_env.xport[1]}, 8'h07, "expander or");
      check({4'h0, u_env.xport[0]}, 8'h08, "expander untouched");
      start();
      put(12'h000, '{8'h43, 8'h20, 8'hA3, 8'hE3, 8'hE7, 8'hF7, 8'h77, 8'hF7});
      put(12'h020, '{8'h96});
      put(12'h396, '{8'hC3});
      go(12'h008);
      check(acc, 8'h0F, "acc after tables and rotates");
      check(program_status_word, 8'h08, "carry after rotates");
      start();
      put(12'h0FD, '{8'h43, 8'h55, 8'hA3, 8'h02, 8'h08});
      put(12'h155, '{8'h6B});
      go(12'h102);
      check(bus_latch, 8'h6B, "page edge table read");
      check(program_status_word, 8'h08, "status after no-ops");
      u_env.stk_lo[7] = 8'h40;
      u_env.stk_hi[7] = 8'hA2;
      u_env.stk_lo[6] = 8'h80;
      u_env.stk_hi[6] = 8'h51;
      start();
      put(12'h000, '{8'h93});
      put(12'h240, '{8'h83});
      go(12'h180);
      check(program_status_word, 8'hAE, "status after returns");
      check(8'(int_end_count), 8'h01, "service end pulses");
      print_verdict();
   end
endmodule : port_table_logic_return_exec_test
